// ### hdl/dtc_timer_pair.sv
`timescale 1ns/10ps
// Notes on behaviour
// - second timer overflow flag, bit 7, set on overflow, cleared on vectoring.
// - bit 6 is second timer run bit; one runs, zero stops.
// - first timer overflow flag, bit 5, set on overflow, cleared on vectoring.
// - bit 4 is first timer run bit; one runs, zero stops.
// - external request b flag, bit 3, set by falling edge or low level.
// - request flags cleared on vectoring only when edge mode; level mode follows pin.
// - bit 2 selects request b trigger: one edge, zero low level.
// - external request a flag, bit 1, set by falling edge or low level.
// - bit 0 selects request a trigger: one edge, zero low level.
// - each timer has high and low count bytes, separate or joined.
// - mode 0 counts 13 bits: high byte over low five bits.
// - mode 0 leaves upper three low-byte bits meaningless to software.
// - wrapping all ones to zero sets the timer overflow flag.
// - counting needs run bit and either gate clear or interrupt pin high.
// - setting run bit never clears the count bytes.
// - mode 1 counts all sixteen bits as one register.
// - mode 2 counts low byte, reloads from high byte on overflow.
// - both timers behave the same in modes 0, 1 and 2.
// - mode field 00 13-bit, 01 16-bit, 10 reload, 11 stopped.
// - timer function advances once per machine cycle of 12 clocks.
// - counter function counts pin falling edges seen over two machine cycles.
// - each timer has its own gate and counter-select bit in mode register.
module dtc_timer_pair #(
  parameter int MACHINE_CYCLE_CLKS = dtc_pkg::DTC_MACHINE_CYCLE_CLKS
) (
  input  wire logic                  CLK_SYS_IN,
  input  wire logic                  NRST_IN,
  input  wire dtc_pkg::dtc_sfr_req_s SFR_REQ_IN,
  input  wire dtc_pkg::dtc_vec_ack_s VEC_ACK_IN,
  input  wire logic                  EXT_IRQ_A_PIN_N_IN,
  input  wire logic                  EXT_IRQ_B_PIN_N_IN,
  input  wire logic                  COUNT_A_PIN_IN,
  input  wire logic                  COUNT_B_PIN_IN,
  output logic [7:0]                 SFR_RDATA_OUT,
  output logic                       FIRST_TIMER_OVF_OUT,
  output logic                       SECOND_TIMER_OVF_OUT,
  output logic                       EXT_IRQ_A_REQ_OUT,
  output logic                       EXT_IRQ_B_REQ_OUT
);
  import dtc_pkg::*;

  localparam int MC_W = $clog2(MACHINE_CYCLE_CLKS);
  localparam logic [MC_W-1:0] MC_LAST = MC_W'(MACHINE_CYCLE_CLKS - 1);

  // control register bits
  logic            second_timer_overflow_flag;
  logic            second_timer_run_bit;
  logic            first_timer_overflow_flag;
  logic            first_timer_run_bit;
  logic            ext_irq_b_request_flag;
  logic            ext_irq_b_trigger_type;
  logic            ext_irq_a_request_flag;
  logic            ext_irq_a_trigger_type;
  logic [7:0]      timer_pair_mode;
  logic [7:0]      rdata;
  logic [7:0]      next_rdata;

  // machine cycle prescaler
  logic [MC_W-1:0] mc_count;
  logic            mc_tick;

  // pin synchronisers, index 0 first timer / request a, index 1 second / b
  logic [1:0]      irq_meta;
  logic [1:0]      irq_sync;
  logic [1:0]      irq_prev;
  logic [1:0]      cnt_meta;
  logic [1:0]      cnt_sync;
  logic [1:0]      cnt_sample;
  logic [1:0]      cnt_fall_seen;

  // per-timer wiring
  logic [1:0]      run_bits;
  logic [1:0]      count_pulse;
  logic [1:0]      overflow_pulse;
  logic [7:0]      low_byte  [2];
  logic [7:0]      high_byte [2];
  logic [1:0]      irq_fall;
  logic            ctl_wr;
  logic            mode_wr;

  assign ctl_wr   = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == DTC_ADDR_CONTROL);
  assign mode_wr  = SFR_REQ_IN.wr && (SFR_REQ_IN.addr == DTC_ADDR_MODE);
  assign run_bits = {second_timer_run_bit, first_timer_run_bit};
  assign irq_fall = irq_prev & ~irq_sync;
  assign mc_tick  = (mc_count == MC_LAST);

  // machine cycle counter, one tick every twelve clocks
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      mc_count <= '0;
    end else if (mc_tick) begin
      mc_count <= '0;
    end else begin
      mc_count <= mc_count + MC_W'(1);
    end
  end

  // two-flop synchronisers for the interrupt and count pins
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      irq_meta <= 2'h3;
      irq_sync <= 2'h3;
      irq_prev <= 2'h3;
      cnt_meta <= 2'h0;
      cnt_sync <= 2'h0;
    end else begin
      irq_meta <= {EXT_IRQ_B_PIN_N_IN, EXT_IRQ_A_PIN_N_IN};
      irq_sync <= irq_meta;
      irq_prev <= irq_sync;
      cnt_meta <= {COUNT_B_PIN_IN, COUNT_A_PIN_IN};
      cnt_sync <= cnt_meta;
    end
  end

  // mode register written by software
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      timer_pair_mode <= DTC_MODE_RST;
    end else if (mode_wr) begin
      timer_pair_mode <= SFR_REQ_IN.wdata;
    end
  end

  // both timers built alike, each from its own mode nibble
  generate
    for (genvar i = 0; i < 2; i++) begin : g_timer
      dtc_tcfg_s   cfg;
      dtc_cnt_wr_s cnt_wr;
      logic        source_ok;
      logic        gate_ok;

      assign cfg = dtc_tcfg_s'(timer_pair_mode[i*DTC_MODE_NIBBLE_W +: DTC_MODE_NIBBLE_W]);
      assign cnt_wr.wr_low  = SFR_REQ_IN.wr &&
        (SFR_REQ_IN.addr == ((i == 0) ? DTC_ADDR_FIRST_LOW : DTC_ADDR_SECOND_LOW));
      assign cnt_wr.wr_high = SFR_REQ_IN.wr &&
        (SFR_REQ_IN.addr == ((i == 0) ? DTC_ADDR_FIRST_HIGH : DTC_ADDR_SECOND_HIGH));
      assign cnt_wr.wdata   = SFR_REQ_IN.wdata;

      // count pin sampled once per machine cycle, high then low is a fall
      always_ff @(posedge CLK_SYS_IN) begin
        if (!NRST_IN) begin
          cnt_sample[i]    <= 1'b0;
          cnt_fall_seen[i] <= 1'b0;
        end else if (mc_tick) begin
          cnt_sample[i]    <= cnt_sync[i];
          cnt_fall_seen[i] <= cnt_sample[i] & ~cnt_sync[i];
        end
      end

      // fall detected in one machine cycle is counted at the next tick
      assign source_ok      = cfg.counter_sel ? cnt_fall_seen[i] : 1'b1;
      assign gate_ok        = ~cfg.gate | irq_sync[i];
      assign count_pulse[i] = mc_tick & source_ok & gate_ok & run_bits[i];

      dtc_timer_unit u_unit (
        .clk_in       (CLK_SYS_IN),
        .nrst_in      (NRST_IN),
        .cfg_in       (cfg),
        .count_in     (count_pulse[i]),
        .wr_in        (cnt_wr),
        .low_out      (low_byte[i]),
        .high_out     (high_byte[i]),
        .overflow_out (overflow_pulse[i])
      );
    end
  endgenerate

  // run bits and trigger types written by software; counts are untouched
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      second_timer_run_bit   <= DTC_CONTROL_RST[DTC_CTL_SECOND_RUN];
      first_timer_run_bit    <= DTC_CONTROL_RST[DTC_CTL_FIRST_RUN];
      ext_irq_b_trigger_type <= DTC_CONTROL_RST[DTC_CTL_EXT_B_TYPE];
      ext_irq_a_trigger_type <= DTC_CONTROL_RST[DTC_CTL_EXT_A_TYPE];
    end else if (ctl_wr) begin
      second_timer_run_bit   <= SFR_REQ_IN.wdata[DTC_CTL_SECOND_RUN];
      first_timer_run_bit    <= SFR_REQ_IN.wdata[DTC_CTL_FIRST_RUN];
      ext_irq_b_trigger_type <= SFR_REQ_IN.wdata[DTC_CTL_EXT_B_TYPE];
      ext_irq_a_trigger_type <= SFR_REQ_IN.wdata[DTC_CTL_EXT_A_TYPE];
    end
  end

  // second timer overflow flag, set beats vectoring and software clear
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      second_timer_overflow_flag <= DTC_CONTROL_RST[DTC_CTL_SECOND_OVF];
    end else if (overflow_pulse[1]) begin
      second_timer_overflow_flag <= 1'b1;
    end else if (VEC_ACK_IN.vec_second_timer) begin
      second_timer_overflow_flag <= 1'b0;
    end else if (ctl_wr) begin
      second_timer_overflow_flag <= SFR_REQ_IN.wdata[DTC_CTL_SECOND_OVF];
    end
  end

  // first timer overflow flag, set beats vectoring and software clear
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      first_timer_overflow_flag <= DTC_CONTROL_RST[DTC_CTL_FIRST_OVF];
    end else if (overflow_pulse[0]) begin
      first_timer_overflow_flag <= 1'b1;
    end else if (VEC_ACK_IN.vec_first_timer) begin
      first_timer_overflow_flag <= 1'b0;
    end else if (ctl_wr) begin
      first_timer_overflow_flag <= SFR_REQ_IN.wdata[DTC_CTL_FIRST_OVF];
    end
  end

  // request b flag: follows the pin in level mode, latches falls in edge mode
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      ext_irq_b_request_flag <= DTC_CONTROL_RST[DTC_CTL_EXT_B_REQ];
    end else if (!ext_irq_b_trigger_type) begin
      ext_irq_b_request_flag <= ~irq_sync[1];
    end else if (irq_fall[1]) begin
      ext_irq_b_request_flag <= 1'b1;
    end else if (VEC_ACK_IN.vec_ext_b) begin
      ext_irq_b_request_flag <= 1'b0;
    end else if (ctl_wr) begin
      ext_irq_b_request_flag <= SFR_REQ_IN.wdata[DTC_CTL_EXT_B_REQ];
    end
  end

  // request a flag: follows the pin in level mode, latches falls in edge mode
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      ext_irq_a_request_flag <= DTC_CONTROL_RST[DTC_CTL_EXT_A_REQ];
    end else if (!ext_irq_a_trigger_type) begin
      ext_irq_a_request_flag <= ~irq_sync[0];
    end else if (irq_fall[0]) begin
      ext_irq_a_request_flag <= 1'b1;
    end else if (VEC_ACK_IN.vec_ext_a) begin
      ext_irq_a_request_flag <= 1'b0;
    end else if (ctl_wr) begin
      ext_irq_a_request_flag <= SFR_REQ_IN.wdata[DTC_CTL_EXT_A_REQ];
    end
  end

  // read data selection, unmapped addresses read zero
  always_comb begin
    next_rdata = 8'h00;
    if (SFR_REQ_IN.addr == DTC_ADDR_CONTROL) begin
      next_rdata = {second_timer_overflow_flag, second_timer_run_bit,
                    first_timer_overflow_flag, first_timer_run_bit,
                    ext_irq_b_request_flag, ext_irq_b_trigger_type,
                    ext_irq_a_request_flag, ext_irq_a_trigger_type};
    end else if (SFR_REQ_IN.addr == DTC_ADDR_MODE) begin
      next_rdata = timer_pair_mode;
    end else if (SFR_REQ_IN.addr == DTC_ADDR_FIRST_LOW) begin
      next_rdata = low_byte[0];
    end else if (SFR_REQ_IN.addr == DTC_ADDR_SECOND_LOW) begin
      next_rdata = low_byte[1];
    end else if (SFR_REQ_IN.addr == DTC_ADDR_FIRST_HIGH) begin
      next_rdata = high_byte[0];
    end else if (SFR_REQ_IN.addr == DTC_ADDR_SECOND_HIGH) begin
      next_rdata = high_byte[1];
    end
  end

  // registered read data, one cycle behind the address
  always_ff @(posedge CLK_SYS_IN) begin
    if (!NRST_IN) begin
      rdata <= 8'h00;
    end else begin
      rdata <= next_rdata;
    end
  end

  // outputs straight from the flag and read flops
  assign SFR_RDATA_OUT        = rdata;
  assign FIRST_TIMER_OVF_OUT  = first_timer_overflow_flag;
  assign SECOND_TIMER_OVF_OUT = second_timer_overflow_flag;
  assign EXT_IRQ_A_REQ_OUT    = ext_irq_a_request_flag;
  assign EXT_IRQ_B_REQ_OUT    = ext_irq_b_request_flag;

endmodule : dtc_timer_pair

// ### hdl/dtc_pkg.sv
package dtc_pkg;

  // register addresses on the special function register port
  localparam logic [7:0] DTC_ADDR_CONTROL     = 8'h88;
  localparam logic [7:0] DTC_ADDR_MODE        = 8'h89;
  localparam logic [7:0] DTC_ADDR_FIRST_LOW   = 8'h8A;
  localparam logic [7:0] DTC_ADDR_SECOND_LOW  = 8'h8B;
  localparam logic [7:0] DTC_ADDR_FIRST_HIGH  = 8'h8C;
  localparam logic [7:0] DTC_ADDR_SECOND_HIGH = 8'h8D;

  // bit positions in the shared control register
  localparam int DTC_CTL_SECOND_OVF  = 7;
  localparam int DTC_CTL_SECOND_RUN  = 6;
  localparam int DTC_CTL_FIRST_OVF   = 5;
  localparam int DTC_CTL_FIRST_RUN   = 4;
  localparam int DTC_CTL_EXT_B_REQ   = 3;
  localparam int DTC_CTL_EXT_B_TYPE  = 2;
  localparam int DTC_CTL_EXT_A_REQ   = 1;
  localparam int DTC_CTL_EXT_A_TYPE  = 0;

  // per-timer nibble of the mode register: second timer high, first low
  localparam int DTC_MODE_NIBBLE_W   = 4;
  localparam int DTC_MODE_FIRST_LSB  = 0;
  localparam int DTC_MODE_SECOND_LSB = 4;

  // reset values
  localparam logic [7:0] DTC_CONTROL_RST = 8'h00;
  localparam logic [7:0] DTC_MODE_RST    = 8'h00;
  localparam logic [7:0] DTC_COUNT_RST   = 8'h00;

  // timing: core clock periods per machine cycle, and low-byte prescaler width
  localparam int DTC_MACHINE_CYCLE_CLKS = 12;
  localparam int DTC_PRESCALE_BITS      = 5;

  // counting modes
  typedef enum logic [1:0] {
    DTC_MODE_13BIT       = 2'b00,
    DTC_MODE_16BIT       = 2'b01,
    DTC_MODE_8BIT_RELOAD = 2'b10,
    DTC_MODE_STOPPED     = 2'b11
  } dtc_mode_e;

  // one timer's configuration nibble, pin gate at the top
  typedef struct packed {
    logic      gate;
    logic      counter_sel;
    dtc_mode_e mode;
  } dtc_tcfg_s;

  // write request on the special function register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
  } dtc_sfr_req_s;

  // software write into one timer's count bytes
  typedef struct packed {
    logic       wr_low;
    logic       wr_high;
    logic [7:0] wdata;
  } dtc_cnt_wr_s;

  // vectoring acknowledges from the interrupt controller
  typedef struct packed {
    logic vec_first_timer;
    logic vec_second_timer;
    logic vec_ext_a;
    logic vec_ext_b;
  } dtc_vec_ack_s;

endpackage : dtc_pkg

// ### hdl/dtc_timer_unit.sv
`timescale 1ns/10ps
module dtc_timer_unit (
  input  wire logic                clk_in,
  input  wire logic                nrst_in,
  input  wire dtc_pkg::dtc_tcfg_s  cfg_in,
  input  wire logic                count_in,
  input  wire dtc_pkg::dtc_cnt_wr_s wr_in,
  output logic [7:0]               low_out,
  output logic [7:0]               high_out,
  output logic                     overflow_out
);
  import dtc_pkg::*;

  logic [7:0]  low;
  logic [7:0]  high;
  logic        overflow;
  logic [7:0]  next_low;
  logic [7:0]  next_high;
  logic        next_overflow;
  logic [12:0] sum13;
  logic [15:0] sum16;

  // next count value for the selected mode
  always_comb begin
    next_low      = low;
    next_high     = high;
    next_overflow = 1'b0;
    sum13         = {high, low[DTC_PRESCALE_BITS-1:0]} + 13'h0001;
    sum16         = {high, low} + 16'h0001;
    if (wr_in.wr_low || wr_in.wr_high) begin
      if (wr_in.wr_low) begin
        next_low = wr_in.wdata;
      end
      if (wr_in.wr_high) begin
        next_high = wr_in.wdata;
      end
    end else if (count_in) begin
      case (cfg_in.mode)
        DTC_MODE_13BIT: begin
          // upper low bits are left as they are
          next_low      = {low[7:DTC_PRESCALE_BITS], sum13[DTC_PRESCALE_BITS-1:0]};
          next_high     = sum13[12:DTC_PRESCALE_BITS];
          next_overflow = &{high, low[DTC_PRESCALE_BITS-1:0]};
        end
        DTC_MODE_16BIT: begin
          next_low      = sum16[7:0];
          next_high     = sum16[15:8];
          next_overflow = &{high, low};
        end
        DTC_MODE_8BIT_RELOAD: begin
          if (&low) begin
            next_low      = high;
            next_overflow = 1'b1;
          end else begin
            next_low = low + 8'h01;
          end
        end
        default: begin
          next_low = low; // stopped: hold
        end
      endcase
    end
  end

  // count bytes and overflow pulse
  always_ff @(posedge clk_in) begin
    if (!nrst_in) begin
      low      <= DTC_COUNT_RST;
      high     <= DTC_COUNT_RST;
      overflow <= 1'b0;
    end else begin
      low      <= next_low;
      high     <= next_high;
      overflow <= next_overflow;
    end
  end

  assign low_out      = low;
  assign high_out     = high;
  assign overflow_out = overflow;

endmodule : dtc_timer_unit

// ### tb/dtc_timer_pair_checker.sv
`timescale 1ns/10ps
module dtc_timer_pair_checker
  import dtc_pkg::*;
#(
  parameter int MACHINE_CYCLE_CLKS = DTC_MACHINE_CYCLE_CLKS
) (
  input wire logic                  CLK_SYS_IN,
  input wire logic                  NRST_IN,
  input wire dtc_pkg::dtc_sfr_req_s SFR_REQ_IN,
  input wire dtc_pkg::dtc_vec_ack_s VEC_ACK_IN,
  input wire logic                  EXT_IRQ_A_PIN_N_IN,
  input wire logic                  EXT_IRQ_B_PIN_N_IN,
  input wire logic                  COUNT_A_PIN_IN,
  input wire logic                  COUNT_B_PIN_IN,
  input wire logic [7:0]            SFR_RDATA_OUT,
  input wire logic                  FIRST_TIMER_OVF_OUT,
  input wire logic                  SECOND_TIMER_OVF_OUT,
  input wire logic                  EXT_IRQ_A_REQ_OUT,
  input wire logic                  EXT_IRQ_B_REQ_OUT
);
  // decoded port activity
  logic ctl_wr;
  logic mapped;
  assign ctl_wr = SFR_REQ_IN.wr && SFR_REQ_IN.addr == DTC_ADDR_CONTROL;
  assign mapped = SFR_REQ_IN.addr inside {[DTC_ADDR_CONTROL:DTC_ADDR_SECOND_HIGH]};
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (!NRST_IN);
  // read port: unmapped, control flags, count write echo
  AST_UNMAPPED_ZERO: assert property (!mapped |=> SFR_RDATA_OUT == 8'h00)
    else $error("unmapped read not zero");
  AST_CTL_OVF_BITS: assert property (SFR_REQ_IN.addr == DTC_ADDR_CONTROL |=>
      SFR_RDATA_OUT[7] == $past(SECOND_TIMER_OVF_OUT) &&
      SFR_RDATA_OUT[5] == $past(FIRST_TIMER_OVF_OUT))
    else $error("control read overflow bits wrong");
  AST_CTL_REQ_BITS: assert property (SFR_REQ_IN.addr == DTC_ADDR_CONTROL |=>
      SFR_RDATA_OUT[3] == $past(EXT_IRQ_B_REQ_OUT) && SFR_RDATA_OUT[1] == $past(EXT_IRQ_A_REQ_OUT))
    else $error("control read request bits wrong");
  AST_COUNT_WRITE_WINS: assert property (
      SFR_REQ_IN.wr && SFR_REQ_IN.addr == DTC_ADDR_FIRST_LOW ##1
      SFR_REQ_IN.addr == DTC_ADDR_FIRST_LOW |=> SFR_RDATA_OUT == $past(SFR_REQ_IN.wdata, 2))
    else $error("count write did not land");
  // overflow flags: cleared by vectoring, held unless vectored or control written
  AST_ACK_CLEARS_FIRST: assert property (VEC_ACK_IN.vec_first_timer |=> !FIRST_TIMER_OVF_OUT)
    else $error("first overflow not cleared by vector");
  AST_ACK_CLEARS_SECOND: assert property (VEC_ACK_IN.vec_second_timer |=> !SECOND_TIMER_OVF_OUT)
    else $error("second overflow not cleared by vector");
  AST_FIRST_OVF_HOLDS: assert property (
      FIRST_TIMER_OVF_OUT && !VEC_ACK_IN.vec_first_timer && !ctl_wr |=> FIRST_TIMER_OVF_OUT)
    else $error("first overflow dropped without cause");
  AST_SECOND_OVF_HOLDS: assert property (
      SECOND_TIMER_OVF_OUT && !VEC_ACK_IN.vec_second_timer && !ctl_wr |=> SECOND_TIMER_OVF_OUT)
    else $error("second overflow dropped without cause");
  // request flags rise only after the pin went low or a control write
  AST_REQ_A_CAUSE: assert property ($rose(EXT_IRQ_A_REQ_OUT) |-> $past(ctl_wr) ||
      !$past(EXT_IRQ_A_PIN_N_IN, 2) || !$past(EXT_IRQ_A_PIN_N_IN, 3) || !$past(EXT_IRQ_A_PIN_N_IN, 4))
    else $error("request a set without pin low");
  AST_REQ_B_CAUSE: assert property ($rose(EXT_IRQ_B_REQ_OUT) |-> $past(ctl_wr) ||
      !$past(EXT_IRQ_B_PIN_N_IN, 2) || !$past(EXT_IRQ_B_PIN_N_IN, 3) || !$past(EXT_IRQ_B_PIN_N_IN, 4))
    else $error("request b set without pin low");
endmodule : dtc_timer_pair_checker

bind dtc_timer_pair dtc_timer_pair_checker #(.MACHINE_CYCLE_CLKS(MACHINE_CYCLE_CLKS)) u_checker (
  .CLK_SYS_IN, .NRST_IN, .SFR_REQ_IN, .VEC_ACK_IN, .EXT_IRQ_A_PIN_N_IN, .EXT_IRQ_B_PIN_N_IN,
  .COUNT_A_PIN_IN, .COUNT_B_PIN_IN, .SFR_RDATA_OUT, .FIRST_TIMER_OVF_OUT, .SECOND_TIMER_OVF_OUT,
  .EXT_IRQ_A_REQ_OUT, .EXT_IRQ_B_REQ_OUT);

// ### tb/dtc_pin_model.sv
`timescale 1ns/10ps
module dtc_pin_model (
  input  wire logic clk_in,
  output logic      irq_a_n_out,
  output logic      irq_b_n_out,
  output logic      cnt_a_out,
  output logic      cnt_b_out
);
  // pins idle high
  initial begin
    irq_a_n_out = 1'b1;
    irq_b_n_out = 1'b1;
    cnt_a_out   = 1'b1;
    cnt_b_out   = 1'b1;
  end
  // count source: every level held hold clocks, at least one machine cycle
  task automatic pulses(input bit second, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      repeat (hold) @(posedge clk_in);
      if (second) cnt_b_out <= 1'b0; else cnt_a_out <= 1'b0;
      repeat (hold) @(posedge clk_in);
      if (second) cnt_b_out <= 1'b1; else cnt_a_out <= 1'b1;
    end
  endtask : pulses
  // interrupt pin level
  task automatic irq(input bit second, input bit lvl);
    @(posedge clk_in);
    if (second) irq_b_n_out <= lvl; else irq_a_n_out <= lvl;
  endtask : irq
endmodule : dtc_pin_model

// ### tb/testbench.sv
`timescale 1ns/10ps
module testbench;
  import dtc_pkg::*;
  localparam int MC = 8;
  `define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin failures++; \
    $display("Error t=%0t got %h exp %h", $time, (g), (e)); end end
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  dtc_sfr_req_s req = '0;
  dtc_vec_ack_s ack = '0;
  logic [7:0]   rdata, hi, lo;
  logic         ovf_a, ovf_b, req_a, req_b;
  wire          irq_a_n, irq_b_n, cnt_a, cnt_b;
  logic [31:0]  r;
  logic [15:0]  v;
  logic [16:0]  want;
  int           failures = 0, n_tests = 0, seed = 88, n;
  logic [7:0]   addrs [6] = '{8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D};
  // 200 MHz clock
  always #2.5 clk = ~clk;
  dtc_timer_pair #(.MACHINE_CYCLE_CLKS(MC)) dut (
    .CLK_SYS_IN(clk), .NRST_IN(nrst), .SFR_REQ_IN(req), .VEC_ACK_IN(ack),
    .EXT_IRQ_A_PIN_N_IN(irq_a_n), .EXT_IRQ_B_PIN_N_IN(irq_b_n), .COUNT_A_PIN_IN(cnt_a),
    .COUNT_B_PIN_IN(cnt_b), .SFR_RDATA_OUT(rdata), .FIRST_TIMER_OVF_OUT(ovf_a),
    .SECOND_TIMER_OVF_OUT(ovf_b), .EXT_IRQ_A_REQ_OUT(req_a), .EXT_IRQ_B_REQ_OUT(req_b));
  dtc_pin_model pins (.clk_in(clk), .irq_a_n_out(irq_a_n), .irq_b_n_out(irq_b_n),
    .cnt_a_out(cnt_a), .cnt_b_out(cnt_b));
  // register write, strobe high one cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr
  // register read, data one cycle after the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    @(posedge clk);
    #1 d = rdata;
  endtask : rd
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK(d, e)
  endtask : chk_reg
  task automatic rd16(input bit t, output logic [15:0] d);
    rd(t ? 8'h8D : 8'h8C, d[15:8]);
    rd(t ? 8'h8B : 8'h8A, d[7:0]);
  endtask : rd16
  // one-cycle vectoring pulse, flags settled on return
  task automatic pulse(input dtc_vec_ack_s a);
    @(posedge clk);
    ack <= a;
    @(posedge clk);
    ack <= '0;
    #1;
  endtask : pulse
  // bounded wait for an overflow flag
  task automatic wait_ovf(input bit t, input int lim);
    int i;
    for (i = 0; i < lim && (t ? ovf_b : ovf_a) !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    `CHK(i < lim, 1'b1)
  endtask : wait_ovf
  // count model: {overflow, high, low} after n counts
  function automatic logic [16:0] model(input int m, input int h, input int l, input int k);
    int x;
    int ov = 0;
    x = (m == 0) ? h * 32 + l % 32 + k : h * 256 + l + k;
    if (m == 0) return {x >= 8192, x[12:5], l[7:5], x[4:0]};
    if (m == 1) return {x >= 65536, x[15:0]};
    for (int i = 0; i < k; i++) begin
      ov |= (l == 255);
      l = (l == 255) ? h : l + 1;
    end
    return {ov[0], h[7:0], l[7:0]};
  endfunction : model
  task automatic conclude;
    $display("comparisons %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : conclude
  // watchdog well beyond the expected run
  initial begin
    #(20000 * 5);
    failures++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    foreach (addrs[i]) chk_reg(addrs[i], 8'h00);
    wr(8'h90, 8'hFF);
    chk_reg(8'h90, 8'h00);
    $display("test reset done");
    for (int i = 1; i < 6; i++) begin
      r = $random(seed);
      wr(addrs[i], r[7:0]);
      chk_reg(addrs[i], r[7:0]);
    end
    $display("test registers done");
    // wrap, overflow and vectoring per mode and timer
    for (int t = 0; t < 2; t++) begin
      for (int m = 0; m < 3; m++) begin
        r = $random(seed);
        hi = (m == 2) ? r[15:8] : 8'hFF;
        lo = (m == 0) ? {r[7:5], 5'h1E} : 8'hFE;
        want = model(m, hi, lo, 2);
        wr(8'h89, 8'(m << 4 * t));
        wr(t ? 8'h8D : 8'h8C, hi);
        wr(t ? 8'h8B : 8'h8A, lo);
        wr(8'h88, t ? 8'h40 : 8'h10);
        wait_ovf(t, 4 * MC + 8);
        wr(8'h88, t ? 8'h80 : 8'h20);
        rd16(t, v);
        `CHK({1'b1, v}, want)
        pulse(t ? 4'h4 : 4'h8);
        `CHK(t ? ovf_b : ovf_a, 1'b0)
      end
    end
    $display("test overflow done");
    // gating by the pin, resume from loaded value, machine-cycle rate
    wr(8'h89, 8'h09);
    wr(8'h8C, 8'h12);
    wr(8'h8A, 8'h34);
    pins.irq(0, 1'b0);
    wr(8'h88, 8'h10);
    repeat (10 * MC) @(posedge clk);
    rd16(0, v);
    `CHK(v, 16'h1234)
    pins.irq(0, 1'b1);
    repeat (20 * MC) @(posedge clk);
    wr(8'h88, 8'h00);
    rd16(0, v);
    want = model(1, 8'h12, 8'h34, 20);
    `CHK(v + 16'h1 >= want[15:0] && v <= want[15:0] + 16'h1, 1'b1)
    // stopped mode holds the count although the run bit is set
    want = {1'b0, v};
    wr(8'h89, 8'h03);
    wr(8'h88, 8'h10);
    repeat (3 * MC) @(posedge clk);
    rd16(0, v);
    `CHK(v, want[15:0])
    // a held software write beats the running count at every tick
    wr(8'h89, 8'h01);
    @(posedge clk);
    req <= '{8'h8A, 8'h55, 1'b1};
    @(posedge clk);
    for (int i = 0; i < 2 * MC; i++) begin
      @(posedge clk);
      #1;
      `CHK(rdata, 8'h55)
    end
    @(posedge clk);
    req <= '{8'h88, 8'h00, 1'b1};
    @(posedge clk);
    req.wr <= 1'b0;
    $display("test gate done");
    // external count pin
    for (int t = 0; t < 2; t++) begin
      n = 3 + $unsigned($random(seed)) % 4;
      wr(8'h89, t ? 8'h50 : 8'h05);
      wr(t ? 8'h8D : 8'h8C, 8'h00);
      wr(t ? 8'h8B : 8'h8A, 8'h00);
      wr(8'h88, t ? 8'h40 : 8'h10);
      pins.pulses(t, n, MC);
      repeat (3 * MC) @(posedge clk);
      wr(8'h88, 8'h00);
      rd16(t, v);
      want = model(1, 0, 0, n);
      `CHK(v, want[15:0])
    end
    $display("test counter done");
    // request flags: level follows pin, edge latched until vectoring
    for (int c = 0; c < 2; c++) begin
      for (int e = 0; e < 2; e++) begin
        wr(8'h88, 8'(e << 2 * c));
        pins.irq(c, 1'b0);
        repeat (6) @(posedge clk);
        #1;
        `CHK(c ? req_b : req_a, 1'b1)
        pulse(c ? 4'h1 : 4'h2);
        `CHK(c ? req_b : req_a, !e[0])
        pins.irq(c, 1'b1);
        repeat (6) @(posedge clk);
        #1;
        `CHK(c ? req_b : req_a, 1'b0)
      end
    end
    $display("test requests done");
    conclude();
  end
endmodule : testbench
